// file: gic_interval_counter_unit.sv
// Gated 16-bit interval counter with an AXI4-Lite register slave and a level interrupt.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "gic_regs.svh"

module gic_interval_counter_unit (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ext_clk_pin,
  input  wire logic        gate_pin,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             counter_irq,
  output logic [2:0]       counter_irq_priority
);

  // Registered state and its next value.
  gic_pkg::gic_state_t q, d;

  // Prescaler terminal count for each prescale select code.
  function automatic logic [7:0] ps_limit(input logic [1:0] sel);
    logic [7:0] lim;
    unique case (sel)
      2'h0: lim = `GIC_PS_LIM0;
      2'h1: lim = `GIC_PS_LIM1;
      2'h2: lim = `GIC_PS_LIM2;
      2'h3: lim = `GIC_PS_LIM3;
    endcase
    return lim;
  endfunction

  // Byte-lane merge of a 16-bit register with the low two write strobes.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // Helper terms derived from the state; pins are read only after two flops.
  logic ext_rise;   // Synchronised rising edge of the external clock pin.
  logic gate_fall;  // Synchronised falling edge of the gate pin.
  logic gated;      // Gated accumulation active on the internal clock.
  logic advance;    // Prescaler input event this cycle.
  logic tick;       // Prescaled counting tick.
  logic match;      // Count equals the period value.
  logic do_wr;      // Register write carried out this cycle.
  logic rd_take;    // Read address taken this cycle.

  assign ext_rise  = q.ext_sy[1] & ~q.ext_sy[2];
  assign gate_fall = ~q.gate_sy[1] & q.gate_sy[2];
  assign gated     = q.gate_en & ~q.src_sel;
  // With one clock both external modes see the pin through the same synchroniser,
  // so the sync select is kept and read back but both settings count the same edge.
  // There is no low-power input, so while run enable is set only a low gate in gated mode pauses counting.
  assign advance   = q.run & (q.src_sel ? ext_rise : 1'b1) & (~gated | q.gate_sy[1]);
  assign tick      = advance & (q.pre == ps_limit(q.psel));
  assign match     = q.count == q.period;
  assign do_wr     = q.aw_have & q.w_have & ~q.bvalid;
  assign rd_take   = s_axi_arvalid & q.arready;

  // Next-state logic for the counter, the synchronisers and the bus slave.
  always_comb begin
    logic [1:0]  ev;
    logic [1:0]  clr;
    logic [31:0] rd;
    logic        rd_ok;
    ev    = 2'h0;
    clr   = 2'h0;
    rd    = 32'h0000_0000;
    rd_ok = 1'b1;
    d     = q;
    // The first flop of each synchroniser feeds only the second.
    d.ext_sy  = {q.ext_sy[1:0], ext_clk_pin};
    d.gate_sy = {q.gate_sy[1:0], gate_pin};
    // Prescaler restarts whenever the counter is stopped.
    if (!q.run) begin
      d.pre = 8'h00;
    end else if (advance) begin
      d.pre = tick ? 8'h00 : q.pre + 8'h01;
    end
    // Count advances on each tick and wraps after matching the period.
    if (tick) begin
      d.count = match ? 16'h0000 : q.count + 16'h0001;
    end
    ev[`GIC_ST_MATCH] = tick & match;
    ev[`GIC_ST_GATE]  = q.run & gated & gate_fall;
    // Write address and data are taken independently and held until used.
    if (s_axi_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.awaddr  = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb  = s_axi_wstrb;
    end
    // A software write to the count wins over a tick in the same cycle.
    if (do_wr) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = `GIC_RESP_OKAY;
      unique case (q.awaddr)
        `GIC_ADDR_CTRL: begin
          if (q.wstrb[0]) begin
            d.gate_en  = q.wdata[`GIC_CTRL_GATE];
            d.psel     = q.wdata[`GIC_CTRL_PS_HI:`GIC_CTRL_PS_LO];
            d.sync_sel = q.wdata[`GIC_CTRL_SYNC];
            d.src_sel  = q.wdata[`GIC_CTRL_SRC];
          end
          if (q.wstrb[1]) begin
            d.run = q.wdata[`GIC_CTRL_RUN];
          end
        end
        `GIC_ADDR_COUNT: d.count = merge16(q.count, q.wdata, q.wstrb);
        `GIC_ADDR_PERIOD: d.period = merge16(q.period, q.wdata, q.wstrb);
        `GIC_ADDR_STATUS: d.bresp = `GIC_RESP_OKAY;
        `GIC_ADDR_MASK: begin
          if (q.wstrb[0]) begin
            d.mask = q.wdata[1:0];
          end
        end
        `GIC_ADDR_PRIO: begin
          if (q.wstrb[0]) begin
            d.prio = q.wdata[2:0];
          end
        end
        default: d.bresp = `GIC_RESP_SLVERR;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // Read decode; reading the status clears what it returns.
    unique case (s_axi_araddr[7:0])
      `GIC_ADDR_CTRL: begin
        rd[`GIC_CTRL_RUN]                      = q.run;
        rd[`GIC_CTRL_GATE]                     = q.gate_en;
        rd[`GIC_CTRL_PS_HI:`GIC_CTRL_PS_LO]    = q.psel;
        rd[`GIC_CTRL_SYNC]                     = q.sync_sel;
        rd[`GIC_CTRL_SRC]                      = q.src_sel;
      end
      `GIC_ADDR_COUNT:  rd[15:0] = q.count;
      `GIC_ADDR_PERIOD: rd[15:0] = q.period;
      `GIC_ADDR_STATUS: begin
        rd[1:0] = q.stat;
        clr     = rd_take ? q.stat : 2'h0;
      end
      `GIC_ADDR_MASK:   rd[1:0] = q.mask;
      `GIC_ADDR_PRIO:   rd[2:0] = q.prio;
      default:          rd_ok = 1'b0;
    endcase
    if (rd_take) begin
      d.rvalid = 1'b1;
      d.rdata  = rd;
      d.rresp  = rd_ok ? `GIC_RESP_OKAY : `GIC_RESP_SLVERR;
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    // An event in the clearing cycle survives: set wins over clear.
    d.stat    = (q.stat & ~clr) | ev;
    d.awready = ~d.aw_have & ~d.bvalid;
    d.wready  = ~d.w_have & ~d.bvalid;
    d.arready = ~d.rvalid;
    d.irq     = |(d.stat & d.mask);
  end

  // Single state register; synchronous active-low reset to constants.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q        <= '0;
      q.period <= `GIC_PERIOD_RST;
    end else begin
      q <= d;
    end
  end

  // All outputs come straight from state flops.
  assign s_axi_awready        = q.awready;
  assign s_axi_wready         = q.wready;
  assign s_axi_bvalid         = q.bvalid;
  assign s_axi_bresp          = q.bresp;
  assign s_axi_arready        = q.arready;
  assign s_axi_rvalid         = q.rvalid;
  assign s_axi_rdata          = q.rdata;
  assign s_axi_rresp          = q.rresp;
  assign counter_irq          = q.irq;
  assign counter_irq_priority = q.prio;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Helper: a count write is pending in this cycle.
  logic cnt_wr;
  assign cnt_wr = do_wr & (q.awaddr == `GIC_ADDR_COUNT);

  property p_wrap;
    tick && match && !cnt_wr |=> q.count == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("Count did not wrap after match.");

  property p_incr;
    tick && !match && !cnt_wr |=> q.count == $past(q.count) + 16'h0001;
  endproperty
  a_incr: assert property (p_incr) else $error("Count did not step on tick.");

  property p_stop;
    !q.run && !cnt_wr |=> $stable(q.count);
  endproperty
  a_stop: assert property (p_stop) else $error("Count moved while stopped.");

  property p_ps;
    tick |-> q.pre == ps_limit(q.psel) && q.run;
  endproperty
  a_ps: assert property (p_ps) else $error("Tick off the prescale limit.");

  property p_src;
    q.src_sel && !(q.ext_sy[1] && !q.ext_sy[2]) |-> !tick;
  endproperty
  a_src: assert property (p_src) else $error("External mode ticked without edge.");

  property p_gate;
    q.run && gated && !q.gate_sy[1] && !cnt_wr |=> $stable(q.count) ##0 $stable(q.pre);
  endproperty
  a_gate: assert property (p_gate) else $error("Count moved with gate low.");

  property p_gfall;
    q.run && gated && gate_fall |=> q.stat[`GIC_ST_GATE];
  endproperty
  a_gfall: assert property (p_gfall) else $error("Gate fall did not flag.");

  property p_match_flag;
    tick && match |=> q.stat[`GIC_ST_MATCH] ##1 (q.irq == |(q.stat & q.mask)) || !q.mask[0];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("Match did not flag.");

  property p_irq;
    q.irq == |(q.stat & q.mask);
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt not equal to masked status.");

  property p_period;
    do_wr && q.awaddr == `GIC_ADDR_PERIOD && q.wstrb[1:0] == 2'h3 |=> q.period == $past(q.wdata[15:0]);
  endproperty
  a_period: assert property (p_period) else $error("Period write lost.");

  // The run bit lives in the upper byte lane and follows its own strobe.
  property p_ctrl_run;
    do_wr && q.awaddr == `GIC_ADDR_CTRL && q.wstrb[1] |=> q.run == $past(q.wdata[`GIC_CTRL_RUN]);
  endproperty
  a_ctrl_run: assert property (p_ctrl_run) else $error("Run enable write lost.");

  // Status bits are sticky: only a read of the status word may clear them.
  property p_sticky;
    q.stat[`GIC_ST_MATCH] && !(rd_take && s_axi_araddr[7:0] == `GIC_ADDR_STATUS) |=> q.stat[`GIC_ST_MATCH];
  endproperty
  a_sticky: assert property (p_sticky) else $error("Match flag dropped without a read.");

  // Gated mode with the gate high counts like the plain internal timer.
  property p_gate_cnt;
    q.run && gated && q.gate_sy[1] && q.pre == ps_limit(q.psel) && !match && !cnt_wr
      |=> q.count == $past(q.count) + 16'h0001;
  endproperty
  a_gate_cnt: assert property (p_gate_cnt) else $error("Gated count did not step.");

  // Each synchronised pin edge at the prescale limit steps the count.
  property p_ext_step;
    q.run && q.src_sel && ext_rise && q.pre == ps_limit(q.psel) && !match && !cnt_wr
      |=> q.count == $past(q.count) + 16'h0001;
  endproperty
  a_ext_step: assert property (p_ext_step) else $error("Pin edge did not step the count.");

  c_match: cover property (tick && match && q.mask[0]);
  c_gated: cover property (q.run && gated && gate_fall);
  c_ext:   cover property (q.src_sel && tick);
  c_slow:  cover property (tick && q.psel == 2'h3);

endmodule

// file: gic_regs.svh
// Register offsets, field positions, reset values and prescale limits of the interval counter.
`ifndef GIC_REGS_SVH
`define GIC_REGS_SVH
`define GIC_ADDR_CTRL    8'h00
`define GIC_ADDR_COUNT   8'h04
`define GIC_ADDR_PERIOD  8'h08
`define GIC_ADDR_STATUS  8'h0C
`define GIC_ADDR_MASK    8'h10
`define GIC_ADDR_PRIO    8'h14
`define GIC_CTRL_RUN     15
`define GIC_CTRL_GATE    6
`define GIC_CTRL_PS_HI   5
`define GIC_CTRL_PS_LO   4
`define GIC_CTRL_SYNC    2
`define GIC_CTRL_SRC     1
`define GIC_ST_MATCH     0
`define GIC_ST_GATE      1
`define GIC_PERIOD_RST   16'hFFFF
`define GIC_PS_LIM0      8'h00
`define GIC_PS_LIM1      8'h07
`define GIC_PS_LIM2      8'h3F
`define GIC_PS_LIM3      8'hFF
`define GIC_RESP_OKAY    2'h0
`define GIC_RESP_SLVERR  2'h2
`endif

// file: gic_pkg.sv
// Types shared by the interval counter design.
package gic_pkg;
  // Whole state of the counter unit, registered in one process.
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] period;
    logic [7:0]  pre;
    logic        run;
    logic [1:0]  psel;
    logic        gate_en;
    logic        sync_sel;
    logic        src_sel;
    logic [2:0]  prio;
    logic [1:0]  stat;
    logic [1:0]  mask;
    logic [2:0]  ext_sy;
    logic [2:0]  gate_sy;
    logic        aw_have;
    logic [7:0]  awaddr;
    logic        w_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        irq;
  } gic_state_t;
endpackage

// file: gic_pin_source.sv
// Far-side model driving the external counting clock and gate pins.
`timescale 1ns/1ps
module gic_pin_source (
  input  wire logic aclk,
  output logic      ext_clk_pin,
  output logic      gate_pin
);
  // Pins rest low; the clock stands still between bursts.
  initial begin
    ext_clk_pin = 1'b0;
    gate_pin    = 1'b0;
  end
  // Sends n rising edges, two cycles high and two low each.
  task automatic clk_burst(input int n);
    repeat (n) begin
      repeat (2) @(posedge aclk) ext_clk_pin <= 1'b1;
      repeat (2) @(posedge aclk) ext_clk_pin <= 1'b0;
    end
  endtask
  // Holds the gate high for exactly n cycles, then drops it.
  task automatic gate_pulse(input int n);
    @(posedge aclk) gate_pin <= 1'b1;
    repeat (n) @(posedge aclk);
    gate_pin <= 1'b0;
  endtask
endmodule

// file: gated_interval_counter_test.sv
// Self-checking bench for the gated interval counter.
`timescale 1ns/1ps
`include "gic_regs.svh"
module gated_interval_counter_test;
  logic        aclk, aresetn, ext_clk_pin, gate_pin, counter_irq;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  counter_irq_priority;
  int          err_total, tests_run, cyc;

  gic_interval_counter_unit dut_u (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .ext_clk_pin          (ext_clk_pin),
    .gate_pin             (gate_pin),
    .s_axi_awvalid        (s_axi_awvalid),
    .s_axi_awready        (s_axi_awready),
    .s_axi_awaddr         (s_axi_awaddr),
    .s_axi_wvalid         (s_axi_wvalid),
    .s_axi_wready         (s_axi_wready),
    .s_axi_wdata          (s_axi_wdata),
    .s_axi_wstrb          (s_axi_wstrb),
    .s_axi_bvalid         (s_axi_bvalid),
    .s_axi_bready         (s_axi_bready),
    .s_axi_bresp          (s_axi_bresp),
    .s_axi_arvalid        (s_axi_arvalid),
    .s_axi_arready        (s_axi_arready),
    .s_axi_araddr         (s_axi_araddr),
    .s_axi_rvalid         (s_axi_rvalid),
    .s_axi_rready         (s_axi_rready),
    .s_axi_rdata          (s_axi_rdata),
    .s_axi_rresp          (s_axi_rresp),
    .counter_irq          (counter_irq),
    .counter_irq_priority (counter_irq_priority)
  );
  gic_pin_source src_u (.aclk(aclk), .ext_clk_pin(ext_clk_pin), .gate_pin(gate_pin));

  // Free-running 250 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask

  // Prints the verdict and stops the run.
  task automatic close_out();
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One write; each channel is released when taken, bready held until bvalid, then one idle edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr  <= {24'h0, a};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  // One read; rready held until rvalid is sampled, then one idle edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Division ratio of each prescale select code.
  function automatic int div(input int ps);
    return (ps == 0) ? 1 : (ps == 1) ? 8 : (ps == 2) ? 64 : 256;
  endfunction

  // Cuts a hang short; the ceiling is well above the longest run.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    logic [31:0] d;
    logic [31:0] v;
    logic [1:0]  r;
    int          e, p, t;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    err_total = 0;
    tests_run = 0;
    void'($urandom(32'hF1C7FBB8));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values of all six words, then one unmapped word.
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4), d, r);
      chk("reset word", (i == 2) ? 32'h0000FFFF : 32'h0, d);
      chk("read resp", (i == 6) ? 32'h2 : 32'h0, {30'h0, r});
    end
    wr(8'h18, $urandom, r);
    chk("unmapped write resp", 32'h2, {30'h0, r});
    // Low byte lane only: run and the upper period byte must keep their reset values.
    s_axi_wstrb <= 4'h1;
    v = $urandom;
    wr(`GIC_ADDR_CTRL, v, r);
    wr(`GIC_ADDR_PERIOD, v, r);
    s_axi_wstrb <= 4'hF;
    rd(`GIC_ADDR_CTRL, d, r);
    chk("control low lane", v & 32'h0000_0076, d);
    rd(`GIC_ADDR_PERIOD, d, r);
    chk("period low lane", {24'h0000FF, v[7:0]}, d);
    d = $urandom;
    wr(`GIC_ADDR_PRIO, d, r);
    @(posedge aclk);
    chk("priority port", {29'h0, d[2:0]}, {29'h0, counter_irq_priority});
    // External counting at every prescale ratio; extra edges while stopped.
    wr(`GIC_ADDR_MASK, 32'h1, r);
    for (int ps = 0; ps < 4; ps++) begin
      p = $urandom_range(9, 2);
      e = $urandom_range(div(ps) * (p + 1) * 2 - 1, 0);
      t = e / div(ps);
      wr(`GIC_ADDR_PERIOD, p, r);
      wr(`GIC_ADDR_COUNT, 32'h0, r);
      rd(`GIC_ADDR_STATUS, d, r);
      wr(`GIC_ADDR_CTRL, 32'h8002 | (ps << 4) | ($urandom_range(1, 0) << 2), r);
      src_u.clk_burst(e);
      repeat (6) @(posedge aclk);
      chk("match irq", t > p, counter_irq);
      wr(`GIC_ADDR_CTRL, 32'h0, r);
      src_u.clk_burst(3);
      rd(`GIC_ADDR_COUNT, d, r);
      chk("count", t % (p + 1), d);
      rd(`GIC_ADDR_STATUS, d, r);
      chk("match flag", t > p, d);
    end
    // Gated internal counting, then the gate-fall interrupt.
    wr(`GIC_ADDR_MASK, 32'h0, r);
    wr(`GIC_ADDR_PERIOD, 32'hFFFF, r);
    wr(`GIC_ADDR_COUNT, 32'h0, r);
    wr(`GIC_ADDR_CTRL, 32'h8040, r);
    repeat (20) @(posedge aclk);
    e = $urandom_range(40, 1);
    src_u.gate_pulse(e);
    repeat (6) @(posedge aclk);
    chk("masked irq", 32'h0, counter_irq);
    wr(`GIC_ADDR_MASK, 32'h2, r);
    @(posedge aclk);
    chk("gate irq", 32'h1, counter_irq);
    wr(`GIC_ADDR_CTRL, 32'h0, r);
    rd(`GIC_ADDR_COUNT, d, r);
    chk("gated count", e, d);
    rd(`GIC_ADDR_STATUS, d, r);
    chk("gate flag", 32'h2, d);
    @(posedge aclk);
    chk("irq after clear", 32'h0, counter_irq);
    close_out();
  end
endmodule
